/* File: verilog/adc_sequence_control.sv */
`timescale 1ns/1ps
module adc_sequence_control
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    input wire logic special_mode,
    input wire logic stop_req,
    input wire logic rc_tick,
    input wire logic comp_out,
    output logic [7:0] trial_value,
    output logic [3:0] mux_select,
    output logic sample_gate,
    output logic charge_pump_on,
    output logic converter_clock_source,
    output logic stop_exit_delay_enable
);
    typedef struct packed {
        apb_rsp_s rsp;
        logic [7:0] ctl;
        logic [7:0] opt;
        logic opt_locked;
        logic [6:0] boot_cnt;
        logic [31:0] res;
        logic start_pend;
        conv_e state;
        logic [3:0] step_cnt;
        logic [7:0] sar;
        logic [2:0] bit_idx;
        logic [1:0] slot;
        logic [3:0] chan;
        logic gate;
        logic res_pend;
        logic [7:0] res_val;
        logic [1:0] res_slot;
        logic done_pend;
    } st_s;

    st_s q, d;
    logic tick;
    logic halted;

    // ========================================
    // Submodules
    adc_tick_gen u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_sel(q.opt[opt_converter_clock_source_bit]),
        .rc_tick(rc_tick),
        .tick(tick)
    );
    adc_stop_delay u_stop (
        .clk(clk),
        .sys_rst(sys_rst),
        .stop_req(stop_req),
        .dly_en(q.opt[opt_dly_bit]),
        .halted(halted)
    );

    // ========================================
    // Channel for a given slot
    function automatic logic [3:0] slot_chan(input logic [7:0] ctl,
                                             input logic [1:0] slot);
        if (ctl[ctl_group_conversion_bit]) begin
            slot_chan = {ctl[3:2], slot};
        end else begin
            slot_chan = ctl[3:0];
        end
    endfunction

    // Read mux
    function automatic logic [31:0] rd_word(input st_s s,
                                            input logic [7:0] a);
        rd_word = 32'h0;
        case (a)
            ctl_addr: rd_word = {24'h0, s.ctl};
            res1_addr: rd_word = {24'h0, s.res[7:0]};
            res2_addr: rd_word = {24'h0, s.res[15:8]};
            res3_addr: rd_word = {24'h0, s.res[23:16]};
            res4_addr: rd_word = {24'h0, s.res[31:24]};
            opt_addr: rd_word = {24'h0, s.opt & opt_wmask};
            mode_addr: rd_word = {31'h0, special_mode};
            default: rd_word = 32'h0;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ctl_addr) || (a == res1_addr) || (a == res2_addr) ||
                  (a == res3_addr) || (a == res4_addr) ||
                  (a == opt_addr) || (a == mode_addr);
    endfunction

    logic acc;
    logic wr;
    logic rd;
    logic ctl_wr;
    logic pwr;
    always_comb begin
        acc = apb_req.psel && apb_req.penable;
        wr = acc && apb_req.pwrite;
        rd = apb_req.psel && !apb_req.pwrite;
        ctl_wr = wr && apb_req.paddr == ctl_addr;
        pwr = q.opt[opt_pwr_bit];
    end

    // ========================================
    // Next state
    always_comb begin
        d = q;
        d.rsp.pready = 1'b0;
        d.rsp.pslverr = 1'b0;
        d.rsp.prdata = 32'h0;
        d.gate = 1'b0;
        // Bus slave: one wait state, answer on second access cycle
        if (acc && !q.rsp.pready) begin
            d.rsp.pready = 1'b1;
            d.rsp.pslverr = !addr_ok(apb_req.paddr);
            d.rsp.prdata = apb_req.pwrite ? 32'h0 : rd_word(q, apb_req.paddr);
        end
        // Protected option window
        if (q.boot_cnt != 7'(prot_win_cyc)) begin
            d.boot_cnt = q.boot_cnt + 7'h01;
        end
        if (wr && !q.rsp.pready && apb_req.paddr == opt_addr) begin
            d.opt[opt_pwr_bit] = apb_req.pwdata[opt_pwr_bit];
            d.opt[opt_converter_clock_source_bit] = apb_req.pwdata[opt_converter_clock_source_bit];
            if (special_mode ||
                (!q.opt_locked && q.boot_cnt != 7'(prot_win_cyc))) begin
                d.opt = (apb_req.pwdata[7:0] & opt_wmask) |
                        (d.opt & ~opt_prot_mask) & opt_wmask;
                d.opt_locked = !special_mode;
            end
        end
        // Conversion engine
        case (q.state)
            st_idle: begin
            end
            st_sample: begin
                d.gate = 1'b1;
                if (tick && !halted) begin
                    if (q.step_cnt == 4'(sample_cyc - 1)) begin
                        d.gate = 1'b0;
                        d.state = st_trial;
                        d.bit_idx = 3'(bit_steps - 1);
                        d.sar = 8'h80;
                    end else begin
                        d.step_cnt = q.step_cnt + 4'h1;
                    end
                end
            end
            st_trial: begin
                if (tick && !halted) begin
                    // Keep or drop trial bit, try next lower; 00..ff span
                    d.sar[q.bit_idx] = comp_out;
                    if (q.bit_idx == 3'h0) begin
                        d.state = st_hold;
                    end else begin
                        d.sar[q.bit_idx - 3'h1] = 1'b1;
                        d.bit_idx = q.bit_idx - 3'h1;
                    end
                end
            end
            st_hold: begin
                d.res_pend = 1'b1;
                d.res_val = q.sar;
                d.res_slot = q.slot;
                d.done_pend = (q.slot == 2'(conv_count - 1));
                d.slot = q.slot + 2'h1;
                d.chan = slot_chan(q.ctl, q.slot + 2'h1);
                d.step_cnt = 4'h0;
                if (q.slot == 2'(conv_count - 1) &&
                    !q.ctl[ctl_scan_bit]) begin
                    d.state = st_idle;
                end else begin
                    d.state = st_sample;
                    d.gate = 1'b1;
                end
            end
            default: d.state = st_idle;
        endcase
        // Result update deferred while a read is on the bus
        if (q.res_pend && !rd) begin
            d.res[q.res_slot*8 +: 8] = q.res_val;
            d.res_pend = 1'b0;
            if (q.done_pend) begin
                d.ctl[ctl_done_bit] = 1'b1;
                d.done_pend = 1'b0;
            end
        end
        if (!pwr) begin
            d.state = st_idle;
            d.gate = 1'b0;
            d.start_pend = 1'b0;
        end
        // Start one cycle after the control write
        if (q.start_pend && pwr) begin
            d.start_pend = 1'b0;
            d.state = st_sample;
            d.gate = 1'b1;
            d.slot = 2'h0;
            d.chan = slot_chan(q.ctl, 2'h0);
            d.step_cnt = 4'h0;
        end
        if (ctl_wr && !q.rsp.pready) begin
            d.ctl = apb_req.pwdata[7:0] & ctl_wmask;
            d.start_pend = pwr;
            d.state = st_idle;
            d.gate = 1'b0;
            d.res_pend = 1'b0;
            d.done_pend = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.ctl <= ctl_rst;
            q.opt <= opt_rst;
            q.state <= st_idle;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // Outputs
    assign apb_rsp = q.rsp;
    assign trial_value = q.sar;
    assign mux_select = q.chan;
    assign sample_gate = q.gate;
    assign charge_pump_on = q.opt[opt_pwr_bit];
    assign converter_clock_source = q.opt[opt_converter_clock_source_bit];
    assign stop_exit_delay_enable = q.opt[opt_dly_bit];
endmodule

/* File: verilog/adc_seq_pkg.sv */
// How it works
// - Each conversion runs eight compare steps, MSB first, into the trial register.
// - A finished conversion copies the trial register into its slot's result.
// - Sequences hold four conversions; continuous mode repeats, else one pass.
// - Done flag sets after the fourth conversion of a sequence.
// - Sequence starts one cycle after a control register write.
// - Low reference gives 00, high reference ff, no overflow flag.
// - Four-bit input selector routes one of 16 sources to the converter.
// - Codes 0-7 port E, 8-11 reserved, 12-14 refs, 15 reserved.
// - Four readable 8-bit results, valid while the done flag is set.
// - Results update on a cycle with no bus read in progress.
// - Control register holds selector, done flag, continuous and group bits.
// - Options bit 7 powers the converter; 0 powers down and disables.
// - Clock-source bit picks bus clock (0) or RC oscillator (1).
// - Stop-exit delay 1 waits 4000 cycles, 0 resumes in four.
// - Protected options take one write in first 64 cycles, any in special.
// - Sample switch closed only for 12 unhalted converter clock ticks per conversion (12 cycles on bus clock, 23 or 24 on RC).
// - Single pass halts after fourth; continuous overwrites slot one onward.
// - Each control write clears done flag; it restarts the sequence only while the converter is powered.
// - Group mode uses upper selector bits; each channel has its own slot.
package adc_seq_pkg;
    // ========================================
    // Register byte addresses
    localparam logic [7:0] ctl_addr = 8'h00;
    localparam logic [7:0] res1_addr = 8'h04;
    localparam logic [7:0] res2_addr = 8'h08;
    localparam logic [7:0] res3_addr = 8'h0c;
    localparam logic [7:0] res4_addr = 8'h10;
    localparam logic [7:0] opt_addr = 8'h14;
    localparam logic [7:0] mode_addr = 8'h18;
    // ========================================
    // Control fields
    localparam int ctl_done_bit = 7;
    localparam int ctl_scan_bit = 5;
    localparam int ctl_group_conversion_bit = 4;
    localparam logic [7:0] ctl_wmask = 8'h3f;
    localparam logic [7:0] ctl_rst = 8'h00;
    // ========================================
    // Option fields
    localparam int opt_pwr_bit = 7;
    localparam int opt_converter_clock_source_bit = 6;
    localparam int opt_dly_bit = 4;
    localparam logic [7:0] opt_wmask = 8'hfb;
    localparam logic [7:0] opt_prot_mask = 8'h3b;
    localparam logic [7:0] opt_rst = 8'h10;
    // ========================================
    // Timing
    localparam int clk_mhz = 125;
    localparam int prot_win_cyc = 64;
    localparam int sample_cyc = 12;
    localparam int bit_steps = 8;
    localparam int conv_count = 4;
    localparam int stop_dly_cyc = 4000;
    localparam int stop_fast_cyc = 4;
    // ========================================
    // Channels
    localparam logic [3:0] ch_vrh = 4'hc;
    localparam logic [3:0] ch_vrl = 4'hd;
    localparam logic [3:0] ch_half = 4'he;

    typedef enum logic [1:0] {st_idle, st_sample, st_trial, st_hold} conv_e;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;
endpackage

/* File: verilog/adc_tick_gen.sv */
`timescale 1ns/1ps
module adc_tick_gen
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_sel,
    input wire logic rc_tick,
    output logic tick
);
    typedef struct packed {
        logic tick;
    } st_s;
    st_s q, d;
    // ========================================
    // Step pace from bus clock or RC oscillator
    always_comb begin
        d = q;
        d.tick = clk_sel ? rc_tick : 1'b1;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign tick = q.tick;
endmodule

/* File: verilog/adc_stop_delay.sv */
`timescale 1ns/1ps
module adc_stop_delay
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stop_req,
    input wire logic dly_en,
    output logic halted
);
    typedef struct packed {
        logic halted;
        logic [11:0] cnt;
    } st_s;
    st_s q, d;
    // ========================================
    // Stop-exit wait counter
    always_comb begin
        d = q;
        if (stop_req) begin
            d.halted = 1'b1;
            d.cnt = dly_en ? 12'(stop_dly_cyc) : 12'(stop_fast_cyc);
        end else if (q.halted) begin
            if (q.cnt <= 12'h001) begin
                d.halted = 1'b0;
            end else begin
                d.cnt = q.cnt - 12'h001;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign halted = q.halted;
endmodule

/* File: verification/adc_analog_model.sv */
`timescale 1ns/1ps
module adc_analog_model
    import adc_seq_pkg::*;
(
    input wire logic [3:0] mux_select,
    input wire logic [7:0] trial_value,
    output logic comp_out
);
    // ========================================
    // Source level per channel
    logic [7:0] vin;
    always_comb begin
        case (mux_select)
            ch_vrh: vin = 8'hff;
            ch_vrl: vin = 8'h00;
            ch_half: vin = 8'h80;
            default: vin = {mux_select[2:0], 5'h15};
        endcase
    end
    // ========================================
    // Comparator, keeps trial bit when not above input
    assign comp_out = (trial_value <= vin);
endmodule

/* File: verification/adc_sequence_control_properties.sv */
`timescale 1ns/1ps
module adc_sequence_control_properties
    import adc_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire apb_req_s apb_req,
    input wire apb_rsp_s apb_rsp,
    input wire logic [7:0] trial_value,
    input wire logic [3:0] mux_select,
    input wire logic sample_gate,
    input wire logic charge_pump_on,
    input wire logic converter_clock_source
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ========================================
    // Bus decode
    logic acc, ctl_wr, opt_wr;
    assign acc = apb_req.psel && apb_req.penable;
    assign ctl_wr = acc && apb_req.pwrite && !apb_rsp.pready
        && apb_req.paddr == ctl_addr;
    assign opt_wr = acc && apb_req.pwrite && apb_rsp.pready
        && apb_req.paddr == opt_addr;
    // ========================================
    // Sample window length counter
    logic [4:0] gate_run;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_run <= 5'h00;
        end else if (!sample_gate) begin
            gate_run <= 5'h00;
        end else if (gate_run != 5'h1f) begin
            gate_run <= gate_run + 5'h01;
        end
    end
    // ========================================
    // Sequences
    sequence s_window_end;
        $fell(sample_gate) && !converter_clock_source && charge_pump_on
            && !$past(ctl_wr);
    endsequence
    sequence s_trials;
        (!sample_gate) [*8];
    endsequence
    // ========================================
    // Properties
    property p_sample_window;
        s_window_end |-> gate_run == 5'h0c;
    endproperty
    property p_msb_first;
        $fell(sample_gate) |-> ##[0:2] (trial_value == 8'h80);
    endproperty
    property p_trial_len;
        s_window_end |-> s_trials;
    endproperty
    property p_mux_hold;
        sample_gate && $past(sample_gate) |-> $stable(mux_select);
    endproperty
    property p_power_gate;
        !charge_pump_on && !$past(charge_pump_on) |-> !sample_gate;
    endproperty
    property p_start_delay;
        ctl_wr && charge_pump_on && !converter_clock_source && !sample_gate
            |-> ##[2:3] sample_gate;
    endproperty
    property p_opt_bits;
        opt_wr |-> charge_pump_on == apb_req.pwdata[7]
            && converter_clock_source == apb_req.pwdata[6];
    endproperty
    property p_pump_cause;
        $changed(charge_pump_on) |-> opt_wr;
    endproperty
    a_sample_window: assert property (p_sample_window)
        else $error("sample window length wrong");
    a_msb_first: assert property (p_msb_first)
        else $error("first trial not msb");
    a_trial_len: assert property (p_trial_len)
        else $error("trial phase too short");
    a_mux_hold: assert property (p_mux_hold)
        else $error("channel moved during sample");
    a_power_gate: assert property (p_power_gate)
        else $error("sampling while powered down");
    a_start_delay: assert property (p_start_delay)
        else $error("sequence start late");
    a_opt_bits: assert property (p_opt_bits)
        else $error("option outputs wrong");
    a_pump_cause: assert property (p_pump_cause)
        else $error("power bit moved without write");
endmodule
bind adc_sequence_control adc_sequence_control_properties u_props (
    .clk(clk),
    .sys_rst(sys_rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .trial_value(trial_value),
    .mux_select(mux_select),
    .sample_gate(sample_gate),
    .charge_pump_on(charge_pump_on),
    .converter_clock_source(converter_clock_source)
);

/* File: verification/adc_sequence_control_tb_top.sv */
`timescale 1ns/1ps
module adc_sequence_control_tb_top;
    import adc_seq_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic special_mode = 1'b0;
    logic rc_tick = 1'b0;
    logic stop_req = 1'b0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    logic comp_out, gate, pump, csrc, dly;
    logic [7:0] trial;
    logic [3:0] msel;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    always @(posedge clk) rc_tick <= ~rc_tick;
    adc_sequence_control u_dut (
        .clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
        .special_mode(special_mode), .stop_req(stop_req),
        .rc_tick(rc_tick),
        .comp_out(comp_out), .trial_value(trial), .mux_select(msel),
        .sample_gate(gate), .charge_pump_on(pump),
        .converter_clock_source(csrc), .stop_exit_delay_enable(dly));
    adc_analog_model u_model (.mux_select(msel), .trial_value(trial),
        .comp_out(comp_out));
    // ========================================
    // Shared tasks
    function automatic logic [31:0] lvl(input logic [3:0] c);
        return {24'h0, c[2:0], 5'h15};
    endfunction
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int k;
        @(posedge clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            conclude();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        do begin
            repeat (8) @(posedge clk);
            xfer(ctl_addr, 1'b0, '0);
            k++;
        end while (rd[7] !== 1'b1 && k < 400);
        if (k >= 400) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic stop_pulse();
        repeat (14) @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
    endtask
    task automatic chk_res(input logic [31:0] e0, e1, e2, e3);
        logic [31:0] e [4];
        e = '{e0, e1, e2, e3};
        for (int i = 0; i < 4; i++) begin
            xfer(res1_addr + 8'(4 * i), 1'b0, '0);
            check(rd, e[i]);
        end
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        xfer(opt_addr, 1'b0, '0);
        check(rd, 32'h10);
        xfer(opt_addr, 1'b1, 32'h13);
        xfer(ctl_addr, 1'b1, 32'h02);
        repeat (60) @(posedge clk);
        xfer(ctl_addr, 1'b0, '0);
        check(rd, 32'h02);
        xfer(opt_addr, 1'b1, 32'hdb);
        xfer(opt_addr, 1'b0, '0);
        check(rd, 32'hd3);
        check(32'(csrc), 32'h1);
        repeat (100 * clk_mhz) @(posedge clk);
        xfer(ctl_addr, 1'b1, 32'h0c);
        wait_done();
        chk_res(32'hff, 32'hff, 32'hff, 32'hff);
        xfer(opt_addr, 1'b1, 32'h80);
        check(32'(csrc), 32'h0);
        xfer(ctl_addr, 1'b1, 32'h03);
        wait_done();
        check(rd, 32'h83);
        chk_res(lvl(3), lvl(3), lvl(3), lvl(3));
        xfer(ctl_addr, 1'b1, 32'h1c);
        xfer(ctl_addr, 1'b0, '0);
        check(rd, 32'h1c);
        wait_done();
        chk_res(32'hff, 32'h00, 32'h80, lvl(4'hf));
        xfer(ctl_addr, 1'b1, 32'h17);
        stop_pulse();
        repeat (2000) @(posedge clk);
        xfer(ctl_addr, 1'b0, '0);
        check(rd, 32'h17);
        wait_done();
        chk_res(lvl(4), lvl(5), lvl(6), lvl(7));
        xfer(res1_addr, 1'b1, 32'haa);
        xfer(res1_addr, 1'b0, '0);
        check(rd, lvl(4));
        xfer(8'h1c, 1'b0, '0);
        check({rd[30:0], err}, 32'h1);
        special_mode <= 1'b1;
        xfer(opt_addr, 1'b1, 32'hab);
        xfer(opt_addr, 1'b0, '0);
        check(rd, 32'hab);
        check(32'(dly), 32'h0);
        xfer(ctl_addr, 1'b1, 32'h22);
        stop_pulse();
        repeat (120) @(posedge clk);
        xfer(ctl_addr, 1'b0, '0);
        check(rd, 32'ha2);
        wait_done();
        repeat (200) @(posedge clk);
        xfer(ctl_addr, 1'b0, '0);
        check(rd, 32'ha2);
        chk_res(lvl(2), lvl(2), lvl(2), lvl(2));
        conclude();
    end
endmodule
